// ### rtl/bsc_pkg.sv
/*
 * Shared constants, types and cycle kinds of the burst SRAM cycle control.
 * Assumes a single 10 MHz clock and a synchronous active-low reset.
 */
package bsc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 17;              // Full array address
    localparam int LOW_W = 2;                // Burst counter bits
    localparam int DATA_W = 18;              // Two bytes plus two parity bits
    localparam int LANE_W = 2;               // Byte lanes
    localparam int FIFO_DEPTH = 16;          // Command buffer entries
    // ------------------------------------------------------------
    // Timing and reset values
    // ------------------------------------------------------------
    localparam int SLEEP_CYC = 2;            // Cycles to enter or leave sleep
    localparam logic [LOW_W-1:0] CNT_RST = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [LANE_W-1:0] ALL_LANES = 2'h3;
    // ------------------------------------------------------------
    // Decoded cycle kinds, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CK_NONE  = 5'h01,                    // Nothing decoded yet
        CK_DESEL = 5'h02,                    // Deselect cycle
        CK_READ  = 5'h04,                    // Read, begin/continue/suspend
        CK_WRITE = 5'h08,                    // Write, begin/continue/suspend
        CK_SLEEP = 5'h10                     // Power-down
    } bsc_cycle_t;
    // ------------------------------------------------------------
    // Array command carried through the buffer
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;                         // 1 = write, 0 = read
        logic [LANE_W-1:0] lanes;            // Lanes written
        logic [ADDR_W-1:0] addr;             // Array address
        logic [DATA_W-1:0] data;             // Write data
    } bsc_cmd_t;
    localparam int CMD_W = $bits(bsc_cmd_t);
endpackage : bsc_pkg

// ### rtl/bsc_fifo.sv
/*
 * Parameterised command buffer in flip-flops with valid/ready on both sides.
 * Assumes the consumer may stall; full refuses input through in_ready_o.
 */
`timescale 1ns/10ps
module bsc_fifo import bsc_pkg::*; #(
    parameter int WIDTH = CMD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem_r [DEPTH];         // Entry storage
    logic [PW:0] wr_ptr_r;                   // Extra bit tells full from empty
    logic [PW:0] rd_ptr_r;
    logic push;                              // Entry accepted
    logic pop;                               // Entry handed out

    assign in_ready_o = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {PW{1'b0}}};
    assign out_valid_o = wr_ptr_r != rd_ptr_r;
    assign out_data_o = mem_r[rd_ptr_r[PW-1:0]];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Per-entry write, no reset needed on data
    for (genvar e = 0; e < DEPTH; e++) begin : g_ent
        always_ff @(posedge sys_clk_i) begin
            if (push && wr_ptr_r[PW-1:0] == PW'(e)) begin
                mem_r[e] <= in_data_i;
            end
        end
    end

    // Pointer update
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule : bsc_fifo

// ### rtl/bsc_burst_ctr.sv
/*
 * Two-bit wrapping burst counter with interleaved or linear order.
 * Assumes load and step are never requested in the same cycle.
 */
`timescale 1ns/10ps
module bsc_burst_ctr import bsc_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic load_i,
    input wire logic [LOW_W-1:0] start_i,
    input wire logic step_i,
    input wire logic order_i,
    output logic [LOW_W-1:0] cur_off_o,
    output logic [LOW_W-1:0] nxt_off_o
);
    logic [LOW_W-1:0] start_r;               // Low bits of burst start
    logic [LOW_W-1:0] count_r;               // Beats taken so far
    logic [LOW_W-1:0] count_nxt;             // Count after one step

    assign count_nxt = count_r + 1'b1;

    // RQ17 wrap and order
    // High order input interleaves, low order input adds modulo four
    assign cur_off_o = order_i ? (start_r ^ count_r) : (start_r + count_r);
    assign nxt_off_o = order_i ? (start_r ^ count_nxt) : (start_r + count_nxt);

    // RQ15 start loads counter
    // State is left alone otherwise, so deselects keep the burst
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            start_r <= CNT_RST;
            count_r <= CNT_RST;
        end else if (load_i) begin
            start_r <= start_i;
            count_r <= CNT_RST;
        end else if (step_i) begin
            count_r <= count_nxt;
        end
    end
endmodule : bsc_burst_ctr

// ### rtl/bsc_cycle_ctrl.sv
/*
 * Cycle decoding and burst address control of a synchronous burst cache memory.
 * Decoded array accesses pass through a command buffer to the array port.
 * Assumes all synchronous inputs meet setup to sys_clk_i, sleep included.
 */
//
// Contract
// RQ1 - Strobe without full chip enable deselects
// RQ2 - Processor or read controller strobe begins read
// RQ3 - Controller strobe with write begins write
// RQ4 - No strobe, step low: advance, read
// RQ5 - No strobe, step low, write: advance, write
// RQ6 - No strobe, step high: hold, read
// RQ7 - No strobe, step high, write: hold, write
// RQ8 - Processor strobe always reads first
// RQ9 - Partner raises output drive before write
// RQ10 - Output drive acts without clock
// RQ11 - Accepted strobe captures address and counter
// RQ12 - Processor strobe wins over controller strobe
// RQ13 - First chip select high ignores processor strobe
// RQ14 - Upper address sampled only when selected
// RQ15 - Low address bits seed burst counter
// RQ16 - Controller strobe is active low, clocked
// RQ17 - Counter wraps, interleaved or linear order
// RQ18 - Sleep floats data, ignores inputs, two cycles
// RQ19 - Write when global or gated lane write
// RQ20 - Address and counter survive deselects
`timescale 1ns/10ps
module bsc_cycle_ctrl import bsc_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic processor_addr_strobe_n_i,
    input wire logic controller_addr_strobe_n_i,
    input wire logic burst_step_n_i,
    input wire logic chip_select_first_n_i,
    input wire logic chip_select_second_i,
    input wire logic chip_select_third_n_i,
    input wire logic all_lane_write_n_i,
    input wire logic lane_write_gate_n_i,
    input wire logic [LANE_W-1:0] lane_select_n_i,
    input wire logic output_drive_n_i,
    input wire logic sleep_request_i,
    input wire logic burst_order_i,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_n_o,
    output logic asleep_o,
    output logic accept_ready_o,
    output logic arr_valid_o,
    output bsc_cmd_t arr_cmd_o,
    input wire logic arr_ready_i,
    input wire logic arr_rvalid_i,
    input wire logic [DATA_W-1:0] arr_rdata_i
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [SLEEP_CYC-1:0] sleep_sh_r;        // Sleep delay line
    logic asleep_r;                          // Power-down reached
    logic awake;                             // Inputs are honoured
    logic sel_all;                           // All three selects active
    logic p_rec;                             // Processor strobe recognised
    logic c_rec;                             // Controller strobe recognised
    logic any_rec;                           // Either strobe recognised
    logic wr_req;                            // Write inputs ask for a write
    logic [LANE_W-1:0] wr_lanes;             // Lanes that a write covers
    logic desel;                             // Deselect this edge
    logic begin_cyc;                         // Burst begins this edge
    logic cont_cyc;                          // Continue or suspend this edge
    logic is_write;                          // Access this edge writes
    logic do_step;                           // Counter advances
    logic buf_ready;                         // Buffer accepts a command
    logic enq;                               // Command enters buffer
    logic [ADDR_W-1:2] base_r;               // Upper address register
    logic [LOW_W-1:0] cur_off;               // Counter offset now
    logic [LOW_W-1:0] nxt_off;               // Counter offset after step
    bsc_cmd_t cmd;                           // Command built this edge
    bsc_cycle_t cycle_r;                     // Last decoded cycle
    bsc_cycle_t cycle_nxt;
    logic rd_drive_r;                        // A read owns the data lines
    logic [DATA_W-1:0] dq_r;                 // Read data held for the pins

    // ------------------------------------------------------------
    // Sleep entry and exit
    // ------------------------------------------------------------
    // RQ18 two-cycle sleep
    // Power state follows the request after three edges either way
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sleep_sh_r <= '0;
            asleep_r <= 1'b0;
        end else begin
            sleep_sh_r <= {sleep_sh_r[SLEEP_CYC-2:0], sleep_request_i};
            asleep_r <= sleep_sh_r[SLEEP_CYC-1];
        end
    end
    // RQ18 inputs ignored
    // Request itself blocks inputs at once; pending accesses in the buffer are kept and still reach the array
    assign awake = !sleep_request_i && !sleep_sh_r[SLEEP_CYC-1];

    // ------------------------------------------------------------
    // Strobe and select decode
    // ------------------------------------------------------------
    assign sel_all = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
    // RQ13 first select gates
    assign p_rec = !processor_addr_strobe_n_i && !chip_select_first_n_i;
    // RQ12 processor strobe wins
    // RQ16 active low strobe
    assign c_rec = !controller_addr_strobe_n_i && !p_rec;
    assign any_rec = p_rec || c_rec;
    // RQ19 write recognition
    // Global write overrides lane writes and covers both bytes with parity
    assign wr_req = !all_lane_write_n_i || (!lane_write_gate_n_i && !(&lane_select_n_i));
    assign wr_lanes = !all_lane_write_n_i ? ALL_LANES : ~lane_select_n_i;

    // RQ1 deselect decode
    assign desel = awake && any_rec && !sel_all;
    assign begin_cyc = awake && any_rec && sel_all;
    // RQ4 no strobe seen
    // Processor strobe with first select high also lands here while the controller strobe is high
    assign cont_cyc = awake && !any_rec && (processor_addr_strobe_n_i || chip_select_first_n_i);
    // RQ8 processor reads first
    // RQ3 controller write
    assign is_write = begin_cyc ? (c_rec && wr_req) : wr_req;
    // Full buffer stalls the burst: the beat is neither taken nor counted
    assign enq = (begin_cyc || cont_cyc) && buf_ready;
    // RQ4 step on advance
    // RQ6 hold when suspended
    assign do_step = cont_cyc && !burst_step_n_i && buf_ready;

    // ------------------------------------------------------------
    // Address register and burst counter
    // ------------------------------------------------------------
    // RQ11 capture full address
    // RQ14 upper bits sampled
    // RQ20 kept over deselects
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            base_r <= ADDR_RST[ADDR_W-1:2];
        end else if (begin_cyc && buf_ready) begin
            base_r <= addr_i[ADDR_W-1:2];
        end
    end

    bsc_burst_ctr u_ctr (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .load_i(begin_cyc && buf_ready),
        .start_i(addr_i[LOW_W-1:0]),
        .step_i(do_step),
        .order_i(burst_order_i),
        .cur_off_o(cur_off),
        .nxt_off_o(nxt_off)
    );

    // ------------------------------------------------------------
    // Command build
    // ------------------------------------------------------------
    // RQ2 external address read
    // RQ5 write next address
    // RQ7 write current address
    always_comb begin
        cmd.write = is_write;
        cmd.lanes = is_write ? wr_lanes : '0;
        cmd.data = dq_i;
        if (begin_cyc) begin
            cmd.addr = addr_i;
        end else if (!burst_step_n_i) begin
            cmd.addr = {base_r, nxt_off};
        end else begin
            cmd.addr = {base_r, cur_off};
        end
    end

    // Command buffer toward the array
    bsc_fifo #(
        .WIDTH(CMD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_buf (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(enq),
        .in_ready_o(buf_ready),
        .in_data_i(cmd),
        .out_valid_o(arr_valid_o),
        .out_ready_i(arr_ready_i),
        .out_data_o(arr_cmd_o)
    );
    assign accept_ready_o = buf_ready;

    // ------------------------------------------------------------
    // Cycle tracking and data line ownership
    // ------------------------------------------------------------
    // Classify the edge for the drive logic
    always_comb begin
        if (!awake) begin
            cycle_nxt = CK_SLEEP;
        end else if (desel) begin
            cycle_nxt = CK_DESEL;
        end else if (enq) begin
            cycle_nxt = is_write ? CK_WRITE : CK_READ;
        end else begin
            cycle_nxt = cycle_r;
        end
    end

    // Last cycle kind
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cycle_r <= CK_NONE;
        end else begin
            cycle_r <= cycle_nxt;
        end
    end

    // Data lines belong to a read only; writes float them whatever drive says
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rd_drive_r <= 1'b0;
        end else begin
            rd_drive_r <= (cycle_nxt == CK_READ);
        end
    end

    // Read data from the array is held for the pins
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            dq_r <= DATA_RST;
        end else if (arr_rvalid_i) begin
            dq_r <= arr_rdata_i;
        end
    end
    assign dq_o = dq_r;
    assign asleep_o = asleep_r;
    // RQ10 unclocked output drive
    // RQ9 partner floats for writes
    // Drive input bypasses the clock so the pins follow it at once
    assign dq_oe_n_o = output_drive_n_i || !rd_drive_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_sleep_held;
        sleep_request_i [*2];
    endsequence
    sequence s_proc_begin;
        awake && p_rec && sel_all && buf_ready;
    endsequence
    // Write beat of a running burst, taken by the buffer
    sequence s_cont_write;
        cont_cyc && wr_req && buf_ready;
    endsequence

    deselect_floats_a: assert property (desel |=> !rd_drive_r && dq_oe_n_o) // RQ1
        else $error("deselect left data driven");
    proc_read_a: assert property (s_proc_begin |=> rd_drive_r && cycle_r == CK_READ) // RQ2
        else $error("processor strobe did not read");
    ctrl_write_a: assert property (awake && c_rec && sel_all && wr_req && buf_ready // RQ3
        |-> enq && cmd.write && cmd.addr == addr_i)
        else $error("controller write not started");
    step_next_a: assert property (do_step |=> u_ctr.count_r == $past(u_ctr.count_r) + 2'h1) // RQ4
        else $error("burst counter did not step");
    suspend_hold_a: assert property (cont_cyc && burst_step_n_i |=> $stable(u_ctr.count_r)) // RQ6
        else $error("burst counter moved on suspend");
    proc_never_write_a: assert property (s_proc_begin |-> enq && !cmd.write) // RQ8
        else $error("processor strobe began a write");
    drive_async_a: assert property (output_drive_n_i |-> dq_oe_n_o) // RQ10
        else $error("data driven with drive inactive");
    capture_addr_a: assert property (begin_cyc && buf_ready // RQ11
        |=> base_r == $past(addr_i[ADDR_W-1:2]) && cur_off == $past(addr_i[LOW_W-1:0]))
        else $error("address not captured");
    strobe_priority_a: assert property (p_rec && !controller_addr_strobe_n_i |-> !c_rec) // RQ12
        else $error("controller strobe not ignored");
    // Flag trails the delay line by one edge, cycle kind does not
    sleep_enter_a: assert property (s_sleep_held |=> cycle_r == CK_SLEEP ##1 asleep_o) // RQ18
        else $error("sleep not reached in two cycles");
    // Counter state, not the offset: the order pin may move meanwhile
    hold_over_desel_a: assert property (desel |=> $stable(base_r) && $stable(u_ctr.start_r) // RQ20
        && $stable(u_ctr.count_r))
        else $error("burst state lost on deselect");

    // Continue writes land one offset on, suspend writes stay put
    next_write_a: assert property (s_cont_write ##0 !burst_step_n_i // RQ5
        |-> enq && cmd.write && cmd.addr == {base_r, nxt_off})
        else $error("continue write went to wrong address");
    cur_write_a: assert property (s_cont_write ##0 burst_step_n_i // RQ7
        |-> enq && cmd.write && cmd.addr == {base_r, cur_off})
        else $error("suspend write went to wrong address");

    // First select high must leave the processor strobe unseen
    proc_gated_a: assert property (!processor_addr_strobe_n_i && chip_select_first_n_i // RQ13
        && controller_addr_strobe_n_i |-> !begin_cyc && !desel && cont_cyc == awake)
        else $error("gated processor strobe acted");
    // Both strobes high means no strobe at all
    strobe_idle_a: assert property (controller_addr_strobe_n_i && processor_addr_strobe_n_i |-> !any_rec) // RQ16
        else $error("strobe seen while both high");

    // Upper bits move only on an accepted begin
    base_hold_a: assert property (!(begin_cyc && buf_ready) |=> $stable(base_r)) // RQ14
        else $error("upper address changed without a begin");
    // Data lines float once a write is taken, whatever drive says
    write_float_a: assert property (enq && is_write |=> dq_oe_n_o) // RQ9
        else $error("data driven after a write");
endmodule : bsc_cycle_ctrl

// ### verification/bsc_array_model.sv
/*
 * Array-side partner: pops commands from the buffer, keeps a word store and
 * returns read data one cycle after the pop.
 * Assumes the controller's clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
module bsc_array_model import bsc_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic stall_i,
    input wire logic arr_valid_i,
    input wire bsc_cmd_t arr_cmd_i,
    output logic arr_ready_o,
    output logic arr_rvalid_o,
    output logic [DATA_W-1:0] arr_rdata_o,
    output int pops_o,
    output bsc_cmd_t last_o
);
    // ------------------------------------------------------------
    // Store and pop logic
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [int]; // Sparse word store
    // Stall makes the model slow on demand
    assign arr_ready_o = !stall_i;
    // One pop per edge; idle read data toggles so stale values never pass
    always @(posedge sys_clk_i) begin
        arr_rvalid_o <= 1'b0;
        arr_rdata_o <= ~arr_rdata_o;
        if (!rst_b_i) begin
            pops_o <= 0;
        end else if (arr_valid_i && arr_ready_o) begin
            pops_o <= pops_o + 1;
            last_o <= arr_cmd_i;
            if (arr_cmd_i.write) begin
                if (!mem.exists(arr_cmd_i.addr)) mem[arr_cmd_i.addr] = 18'h3ffff;
                if (arr_cmd_i.lanes[0]) mem[arr_cmd_i.addr][8:0] = arr_cmd_i.data[8:0];
                if (arr_cmd_i.lanes[1]) mem[arr_cmd_i.addr][17:9] = arr_cmd_i.data[17:9];
            end else begin
                arr_rvalid_o <= 1'b1;
                arr_rdata_o <= mem.exists(arr_cmd_i.addr) ? mem[arr_cmd_i.addr] : 18'h3ffff;
            end
        end
    end
endmodule : bsc_array_model

// ### verification/tb.sv
/*
 * Self-checking bench of the cycle control: decode table, buffer, sleep.
 * Assumes inputs change on the falling edge and the array model sits behind.
 */
`timescale 1ns/10ps
module tb;
    import bsc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic psn, csn, c1n, c2, c3n, stn, gwn, bwn;
        logic [1:0] bsn;
        logic ord;
        logic [16:0] a;
        logic q, w;
        logic [1:0] ln;
        logic [16:0] ea;
    } bsc_row_t;
    logic clk = 0, rst_b = 0, psn, csn, c1n, c2, c3n, stn, gwn, bwn, odn, slp, ord, stall;
    logic [1:0] bsn;
    logic [16:0] a;
    logic [17:0] dq, dq_o, rdata;
    logic dq_oe_n_o, asleep_o, accept_ready_o, arr_valid_o, arr_ready, rvalid;
    bsc_cmd_t cmd, last;
    int pops, n0, fails = 0, checked = 0, cyc = 0;
    bsc_row_t rows [15];
    bsc_row_t idle = '{1,0,1,0,0,1,1,1,2'h3,1,17'h1ffff,0,0,2'h0,17'h0};
    bsc_row_t r;
    always #50 clk = ~clk;
    bsc_cycle_ctrl DUT (.sys_clk_i(clk), .rst_b_i(rst_b), .addr_i(a), .processor_addr_strobe_n_i(psn),
        .controller_addr_strobe_n_i(csn), .burst_step_n_i(stn), .chip_select_first_n_i(c1n),
        .chip_select_second_i(c2), .chip_select_third_n_i(c3n), .all_lane_write_n_i(gwn),
        .lane_write_gate_n_i(bwn), .lane_select_n_i(bsn), .output_drive_n_i(odn), .sleep_request_i(slp),
        .burst_order_i(ord), .dq_i(dq), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .asleep_o(asleep_o),
        .accept_ready_o(accept_ready_o), .arr_valid_o(arr_valid_o), .arr_cmd_o(cmd),
        .arr_ready_i(arr_ready), .arr_rvalid_i(rvalid), .arr_rdata_i(rdata));
    bsc_array_model u_arr (.sys_clk_i(clk), .rst_b_i(rst_b), .stall_i(stall), .arr_valid_i(arr_valid_o),
        .arr_cmd_i(cmd), .arr_ready_o(arr_ready), .arr_rvalid_o(rvalid), .arr_rdata_o(rdata),
        .pops_o(pops), .last_o(last));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compare and count
    task automatic chk(input string nm, input logic [37:0] e, input logic [37:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Pin values of one cycle
    task automatic drive(input bsc_row_t x, input logic [17:0] d);
        {psn, csn, c1n, c2, c3n, stn, gwn, bwn, bsn, ord, a} = {x.psn, x.csn, x.c1n, x.c2, x.c3n,
            x.stn, x.gwn, x.bwn, x.bsn, x.ord, x.a};
        dq = d;
    endtask : drive
    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Hang guard, run needs about 150 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{'{0,1,0,1,0,1,0,1,2'h3,1,17'h12346,1,0,2'h0,17'h12346},
            '{1,1,0,1,0,0,1,1,2'h3,1,17'h1ffff,1,0,2'h0,17'h12347},
            '{1,1,0,1,0,1,1,1,2'h3,1,17'h1ffff,1,0,2'h0,17'h12347},
            '{1,1,0,1,0,0,0,1,2'h3,1,17'h1ffff,1,1,2'h3,17'h12344},
            '{1,1,0,1,0,1,1,0,2'h2,1,17'h1ffff,1,1,2'h1,17'h12344},
            '{1,1,0,1,0,1,1,0,2'h3,1,17'h1ffff,1,0,2'h0,17'h12344},
            '{0,1,1,1,0,0,1,1,2'h3,1,17'h1ffff,1,0,2'h0,17'h12345},
            '{1,0,0,1,0,1,0,1,2'h3,0,17'h0abcf,1,1,2'h3,17'h0abcf},
            '{1,1,0,1,0,0,1,1,2'h3,0,17'h1ffff,1,0,2'h0,17'h0abcc},
            '{0,0,0,1,0,1,0,1,2'h3,0,17'h1fff1,1,0,2'h0,17'h1fff1},
            '{1,0,0,1,0,1,1,1,2'h3,0,17'h00002,1,0,2'h0,17'h00002},
            '{0,1,0,0,0,1,1,1,2'h3,0,17'h1ffff,0,0,2'h0,17'h0},
            '{0,1,0,1,1,1,1,1,2'h3,0,17'h1ffff,0,0,2'h0,17'h0},
            '{1,0,1,1,0,1,0,1,2'h3,0,17'h1ffff,0,0,2'h0,17'h0},
            '{1,1,0,1,0,0,1,1,2'h3,0,17'h1ffff,1,0,2'h0,17'h00003}};
        drive(idle, 18'h0);
        odn = 1;
        slp = 0;
        stall = 0;
        repeat (20) @(negedge clk);
        rst_b = 1;
        chk("rst_oe", 38'h1, {37'h0, dq_oe_n_o});
        chk("rst_flags", 38'h2, {35'h0, asleep_o, accept_ready_o, arr_valid_o});
        chk("rst_dq", 38'h0, {20'h0, dq_o});
        for (int i = 0; i < 15; i++) begin
            n0 = pops;
            @(negedge clk);
            drive(rows[i], 18'h15a5a + 18'(i));
            @(negedge clk);
            drive(idle, 18'h0);
            if (rows[i].q && !rows[i].w) begin
                odn = 0;
                #1 chk("oe_on", 38'h0, {37'h0, dq_oe_n_o});
                odn = 1;
                #1 chk("oe_off", 38'h1, {37'h0, dq_oe_n_o});
            end else begin
                // Writes and deselects float even with drive low
                odn = 0;
                #1 chk("oe_float", 38'h1, {37'h0, dq_oe_n_o});
                odn = 1;
            end
            repeat (3) @(negedge clk);
            chk("queued", 38'(rows[i].q), 38'(pops - n0));
            if (rows[i].q) begin
                chk("addr", 38'(rows[i].ea), 38'(last.addr));
                chk("write", 38'(rows[i].w), 38'(last.write));
                if (rows[i].w) chk("lanes_data", {18'(rows[i].ln), 18'h15a5a + 18'(i)},
                    {18'(last.lanes), last.data});
            end
        end
        // Buffer fills while the array stalls, then drains
        stall = 1;
        r = idle;
        r.csn = 1;
        drive(r, 18'h0);
        n0 = pops;
        repeat (20) @(negedge clk);
        chk("full", 38'h1, {36'h0, accept_ready_o, arr_valid_o});
        drive(idle, 18'h0);
        @(negedge clk);
        stall = 0;
        repeat (20) @(negedge clk);
        chk("drained", 38'd16, 38'(pops - n0));
        chk("empty", 38'h0, {37'h0, arr_valid_o});
        // Sleep: write attempt ignored, data retained
        slp = 1;
        n0 = pops;
        drive(rows[7], 18'h00000);
        @(negedge clk);
        chk("sleep_early", 38'h0, {37'h0, asleep_o});
        repeat (3) @(negedge clk);
        chk("sleep_on", 38'h3, {36'h0, asleep_o, dq_oe_n_o});
        slp = 0;
        drive(idle, 18'h0);
        @(negedge clk);
        chk("wake_early", 38'h1, {37'h0, asleep_o});
        repeat (3) @(negedge clk);
        chk("wake", 38'h0, {37'h0, asleep_o});
        chk("sleep_none", 38'h0, 38'(pops - n0));
        r = rows[0];
        r.a = 17'h0abcf;
        drive(r, 18'h0);
        @(negedge clk);
        drive(idle, 18'h0);
        repeat (5) @(negedge clk);
        chk("readback", 38'(18'h15a61), 38'(dq_o));
        wrap_up();
    end
endmodule : tb
